// ===== rtl/lsc_top.sv
// Load switch control with shared overload interrupt
`timescale 1ns/1ps
module lsc_top
  import lsc_pkg::*;
#(
  parameter int unsigned NUM_SWITCHES = NUM_SWITCHES_DEFAULT,
  parameter int unsigned BASE_CYCLES  = SAFETY_BASE_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic                    first_buck_enabled,
  input  wire logic                    first_buck_good,
  input  wire logic                    second_buck_enabled,
  input  wire logic                    second_buck_good,
  input  wire lsc_ctrl_s               switch_control_register [NUM_SWITCHES],
  input  wire lsc_sense_s              switch_sense [NUM_SWITCHES],
  input  wire logic [NUM_SWITCHES-1:0] overload_mask_write,
  input  wire logic [NUM_SWITCHES-1:0] overload_mask_value,
  input  wire logic                    first_status_write,
  input  wire logic                    first_status_pending_value,
  output logic [NUM_SWITCHES-1:0]      switch_gate,
  output logic [NUM_SWITCHES-1:0]      switch_discharge,
  output logic [NUM_SWITCHES-1:0]      switch_reverse_block,
  output logic [NUM_SWITCHES-1:0]      switch_power_good,
  output logic [NUM_SWITCHES-1:0]      switch_enable_bit,
  output logic [NUM_SWITCHES-1:0]      overload_mask,
  output logic                         first_interrupt_status,
  output logic [NUM_SWITCHES-1:0]      second_interrupt_status,
  output logic                         irq_n_out,
  output logic                         irq_n_oe
);

  logic                    buck_sync1 [4];
  logic                    buck_sync2 [4];
  logic                    buck_sync3 [4];
  logic                    supplies_ok;
  logic [NUM_SWITCHES-1:0] overload_event;
  logic [NUM_SWITCHES-1:0] overload_prev;
  logic [NUM_SWITCHES-1:0] overload_rise;
  logic [NUM_SWITCHES-1:0] flagged;
  lsc_drive_s              drive [NUM_SWITCHES];

  // Buck status pins come from analog, so three stages with agreement
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        buck_sync1[i] <= 1'b0;
        buck_sync2[i] <= 1'b0;
        buck_sync3[i] <= 1'b0;
      end
    end else begin
      buck_sync1[0] <= first_buck_enabled;
      buck_sync1[1] <= first_buck_good;
      buck_sync1[2] <= second_buck_enabled;
      buck_sync1[3] <= second_buck_good;
      for (int i = 0; i < 4; i++) begin
        buck_sync2[i] <= buck_sync1[i];
        buck_sync3[i] <= buck_sync2[i];
      end
    end
  end

  // Agreed level of all four buck states
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      supplies_ok <= 1'b0;
    end else if (buck_sync2[0] == buck_sync3[0] && buck_sync2[1] == buck_sync3[1]
                 && buck_sync2[2] == buck_sync3[2] && buck_sync2[3] == buck_sync3[3]) begin
      supplies_ok <= buck_sync3[0] && buck_sync3[1] && buck_sync3[2] && buck_sync3[3];
    end
  end

  // Sense inputs are assumed already synchronised by the analog wrapper
  for (genvar g = 0; g < NUM_SWITCHES; g++) begin : g_switch
    lsc_switch #(
      .BASE_CYCLES (BASE_CYCLES),
      .REVERSE     (g == REVERSE_SWITCH_INDEX)
    ) u_switch (
      .clk         (clk),
      .reset_n     (reset_n),
      .supplies_ok (supplies_ok),
      .ctrl        (switch_control_register[g]),
      .sense       (switch_sense[g]),
      .drive       (drive[g])
    );
    assign switch_gate[g]          = drive[g].gate_on;
    assign switch_discharge[g]     = drive[g].discharge_on;
    assign switch_reverse_block[g] = drive[g].reverse_block;
    assign switch_power_good[g]    = drive[g].power_good;
    assign switch_enable_bit[g]    = drive[g].enabled;
    assign overload_event[g]       = drive[g].overload_event;
  end

  // Masks come up set so nothing interrupts until software opens it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overload_mask <= '1;
    end else begin
      for (int i = 0; i < NUM_SWITCHES; i++) begin
        if (overload_mask_write[i]) overload_mask[i] <= overload_mask_value[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overload_prev <= '0;
    end else begin
      overload_prev <= overload_event;
    end
  end

  assign overload_rise = overload_event & ~overload_prev;
  assign flagged       = overload_rise & ~overload_mask;

  // Cause bits are captured only on an unmasked event and cleared with the pending bit
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      second_interrupt_status <= '0;
    end else if (|flagged) begin
      second_interrupt_status <= second_interrupt_status | flagged;
    end else if (first_status_write && !first_status_pending_value) begin
      second_interrupt_status <= '0;
    end
  end

  // A new event in the clear cycle keeps the pending bit set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      first_interrupt_status <= 1'b0;
    end else if (|flagged) begin
      first_interrupt_status <= 1'b1;
    end else if (first_status_write && !first_status_pending_value) begin
      first_interrupt_status <= 1'b0;
    end
  end

  // Open-drain pin: drive low only while pending
  assign irq_n_out = 1'b0;
  assign irq_n_oe  = first_interrupt_status;

endmodule : lsc_top

// ===== rtl/lsc_pkg.sv
// Package of constants and carrier types for the load switch controller
package lsc_pkg;

  localparam int unsigned CLK_PERIOD_NS        = 10;
  localparam int unsigned SAFETY_BASE_US       = 200;
  localparam int unsigned SAFETY_BASE_CYCLES   = (SAFETY_BASE_US * 1000 + CLK_PERIOD_NS - 1)
                                                 / CLK_PERIOD_NS;
  localparam int unsigned SAFETY_MAX_FACTOR    = 16;
  localparam int unsigned SAFETY_STEPS         = 4;
  localparam int unsigned TIMER_WIDTH          = 20;
  localparam logic [1:0]  EXTEND_RESET         = 2'h0;
  localparam int unsigned NUM_SWITCHES_DEFAULT = 7;
  localparam int unsigned REVERSE_SWITCH_INDEX = 1;

  typedef struct packed {
    logic       enable_write;
    logic       enable_value;
    logic       discharge_enable;
    logic [1:0] timer_extend;
  } lsc_ctrl_s;

  typedef struct packed {
    logic output_at_input;
    logic output_good;
    logic current_limiting;
    logic over_temperature;
  } lsc_sense_s;

  typedef struct packed {
    logic gate_on;
    logic discharge_on;
    logic reverse_block;
    logic power_good;
    logic overload_event;
    logic enabled;
  } lsc_drive_s;

endpackage : lsc_pkg

// ===== rtl/lsc_switch.sv
// One load switch channel: enable, safety timer, power good, overload and discharge
`timescale 1ns/1ps
module lsc_switch
  import lsc_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = SAFETY_BASE_CYCLES,
  parameter bit          REVERSE     = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       supplies_ok,
  input  wire lsc_ctrl_s  ctrl,
  input  wire lsc_sense_s sense,
  output lsc_drive_s      drive
);

  typedef enum logic [1:0] {LSC_OFF, LSC_RAMP, LSC_ON, LSC_LIMIT} lsc_state_e;

  lsc_state_e             state;
  logic                   enable_bit;
  logic [TIMER_WIDTH-1:0] timer;
  logic [TIMER_WIDTH-1:0] limit;
  logic                   expired;
  logic                   gate;
  logic                   trip;

  // Base period times 1, 2, 4 or 16 selected by software
  function automatic logic [TIMER_WIDTH-1:0] period(input logic [1:0] ext);
    logic [TIMER_WIDTH-1:0] base;
    base = TIMER_WIDTH'(BASE_CYCLES);
    case (ext)
      2'h0:    period = base;
      2'h1:    period = base << 1;
      2'h2:    period = base << 2;
      default: period = base << 4;
    endcase
  endfunction : period

  assign limit   = period(ctrl.timer_extend);
  assign expired = (timer >= limit - TIMER_WIDTH'(1));
  assign gate    = enable_bit && supplies_ok && !sense.over_temperature;
  // Trip mirrors the state machine: reaching the input on the last count is no overload
  assign trip    = gate && expired
                   && (state == LSC_LIMIT || (state == LSC_RAMP && !sense.output_at_input));

  // Enable bit is set only by a host write of one while supplies_ok; a trip, a host write of zero or a write without supplies_ok clears it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      enable_bit <= 1'b0;
    end else if (ctrl.enable_write) begin
      enable_bit <= ctrl.enable_value && supplies_ok;
    end else if (trip) begin
      enable_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= LSC_OFF;
      timer <= '0;
    end else begin
      case (state)
        LSC_OFF: begin
          timer <= '0;
          if (gate) state <= LSC_RAMP;
        end
        LSC_RAMP: begin
          timer <= timer + TIMER_WIDTH'(1);
          if (!gate) state <= LSC_OFF;
          else if (sense.output_at_input) state <= LSC_ON;
          else if (expired) state <= LSC_OFF;
        end
        LSC_ON: begin
          timer <= '0;
          if (!gate) state <= LSC_OFF;
          else if (sense.current_limiting) state <= LSC_LIMIT;
        end
        LSC_LIMIT: begin
          timer <= timer + TIMER_WIDTH'(1);
          if (!gate || expired) state <= LSC_OFF;
          else if (!sense.current_limiting) begin
            state <= LSC_ON;
            timer <= '0;
          end
        end
        default: state <= LSC_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drive <= '0;
    end else begin
      drive.gate_on        <= gate && state != LSC_OFF;
      drive.discharge_on   <= ctrl.discharge_enable && !(gate && state != LSC_OFF);
      drive.reverse_block  <= REVERSE && !(gate && state != LSC_OFF);
      drive.power_good     <= sense.output_good;
      drive.overload_event <= sense.current_limiting && state != LSC_OFF;
      drive.enabled        <= enable_bit;
    end
  end

endmodule : lsc_switch

// ===== test/lsc_load_model.sv
// Load side model: output ramp, stalled ramp, current limiting and hot sensor
`timescale 1ns/1ps
module lsc_load_model
  import lsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic gate,
  input  wire logic stall,
  input  wire logic limit,
  input  wire logic hot,
  output lsc_sense_s sense
);
  logic [3:0] ramp;
  // Output collapses on the next clock while the gate is off; a stall holds it at its level
  always_ff @(posedge clk) begin
    ramp <= !gate ? 4'h0 : (stall || ramp == 4'hF) ? ramp : ramp + 4'h1;
  end
  assign sense.output_at_input  = ramp >= 4'h5;
  assign sense.output_good      = ramp >= 4'h4;
  assign sense.current_limiting = limit && gate;
  assign sense.over_temperature = hot;
endmodule : lsc_load_model

// ===== test/lsc_top_asserts.sv
// Concurrent checks on the load switch controller ports
`timescale 1ns/1ps
module lsc_top_asserts
  import lsc_pkg::*;
#(
  parameter int unsigned NUM_SWITCHES = 2
) (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    first_buck_enabled,
  input wire lsc_sense_s              switch_sense [NUM_SWITCHES],
  input wire logic                    first_status_write,
  input wire logic                    first_status_pending_value,
  input wire logic [NUM_SWITCHES-1:0] switch_gate,
  input wire logic [NUM_SWITCHES-1:0] switch_discharge,
  input wire logic [NUM_SWITCHES-1:0] switch_reverse_block,
  input wire logic [NUM_SWITCHES-1:0] switch_power_good,
  input wire logic [NUM_SWITCHES-1:0] switch_enable_bit,
  input wire logic [NUM_SWITCHES-1:0] overload_mask,
  input wire logic                    first_interrupt_status,
  input wire logic [NUM_SWITCHES-1:0] second_interrupt_status,
  input wire logic                    irq_n_out,
  input wire logic                    irq_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  AST_REV: assert property (!switch_reverse_block[0]) else $error("reverse block on");
  AST_DIS: assert property (switch_gate[0] |-> !switch_discharge[0])
    else $error("discharge while on");
  AST_PG: assert property ($past(reset_n) |->
    switch_power_good[0] == $past(switch_sense[0].output_good)) else $error("power good lag");
  AST_EN: assert property ($rose(switch_gate[0]) |-> switch_enable_bit[0])
    else $error("gate without enable");
  AST_HOT: assert property (switch_sense[0].over_temperature |-> ##[1:3] !switch_gate[0])
    else $error("hot switch stays on");
  AST_BUCK: assert property (!first_buck_enabled |-> ##[1:8] !switch_gate[0])
    else $error("gate on without buck");
  AST_MASK: assert property ($rose(reset_n) |-> &overload_mask) else $error("mask reset");
  AST_PIN: assert property (irq_n_oe == first_interrupt_status && !irq_n_out)
    else $error("irq pin state");
  AST_CLR: assert property (first_status_write && !first_status_pending_value &&
    !switch_sense[0].current_limiting && !$past(switch_sense[0].current_limiting)
    |=> !first_interrupt_status) else $error("pending not cleared");
  AST_OVL: assert property ($rose(switch_sense[0].current_limiting) && switch_gate[0] &&
    !overload_mask[0] |-> ##2 first_interrupt_status && second_interrupt_status[0])
    else $error("overload not flagged");
endmodule : lsc_top_asserts
bind lsc_top lsc_top_asserts #(.NUM_SWITCHES(NUM_SWITCHES)) lsc_top_asserts_inst (.clk, .reset_n,
  .first_buck_enabled, .switch_sense, .first_status_write, .first_status_pending_value,
  .switch_gate, .switch_discharge, .switch_reverse_block, .switch_power_good, .switch_enable_bit,
  .overload_mask, .first_interrupt_status, .second_interrupt_status, .irq_n_out, .irq_n_oe);

// ===== test/lsc_top_tb.sv
// Self-checking bench for the load switch controller
`timescale 1ns/1ps
module lsc_top_tb;
  import lsc_pkg::*;
  localparam int unsigned BC = 20;
  logic          clk, reset_n, b1_en, b1_ok, b2_en, b2_ok, st_wr, st_val, irq_st, irq_o, irq_oe;
  lsc_ctrl_s     ctrl [2];
  lsc_sense_s    sense [2];
  logic [1:0]    m_wr, m_val, stall, limit, hot, gate, dis, rev, pg, en, mask, cause;
  int            bad_count, total_checks, n;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  lsc_top #(.NUM_SWITCHES(2), .BASE_CYCLES(BC)) lsc_top_inst (.clk, .reset_n,
    .first_buck_enabled(b1_en), .first_buck_good(b1_ok), .second_buck_enabled(b2_en),
    .second_buck_good(b2_ok), .switch_control_register(ctrl), .switch_sense(sense),
    .overload_mask_write(m_wr), .overload_mask_value(m_val), .first_status_write(st_wr),
    .first_status_pending_value(st_val), .switch_gate(gate), .switch_discharge(dis),
    .switch_reverse_block(rev), .switch_power_good(pg), .switch_enable_bit(en),
    .overload_mask(mask), .first_interrupt_status(irq_st), .second_interrupt_status(cause),
    .irq_n_out(irq_o), .irq_n_oe(irq_oe));
  for (genvar i = 0; i < 2; i++) begin : g_load
    lsc_load_model lsc_load_model_inst (.clk, .gate(gate[i]), .stall(stall[i]),
      .limit(limit[i]), .hot(hot[i]), .sense(sense[i]));
  end
  task chk(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk
  task tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task wr(int i, logic v, logic [1:0] x);
    @(posedge clk);
    ctrl[i] <= '{1'b1, v, 1'b1, x};
    @(posedge clk);
    ctrl[i].enable_write <= 1'b0;
  endtask : wr
  task await(int i, logic v, int lim);
    #1;
    for (int k = 0; k < lim && gate[i] !== v; k++) tick(1);
    chk("gate", v, gate[i]);
    if (gate[i] !== v) close_out();
  endtask : await
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  task t_blocked;
    tick(1);
    chk("mask", 2'h3, mask);
    wr(0, 1'b1, 2'h0);
    tick(3);
    chk("enable", 0, en[0]);
    chk("gate", 0, gate[0]);
    $display("blocked test done");
  endtask : t_blocked
  task t_on;
    @(posedge clk);
    {b1_en, b1_ok, b2_en, b2_ok} <= 4'hF;
    tick(8);
    chk("discharge", 1, dis[0]);
    chk("reverse", 1, rev[1]);
    wr(0, 1'b1, 2'h0);
    await(0, 1'b1, 5);
    chk("discharge", 0, dis[0]);
    tick(7);
    chk("power good", 1, pg[0]);
    $display("turn on test done");
  endtask : t_on
  task t_timer;
    stall[1] <= 1'b1;
    for (int x = 0; x < 4; x++) begin
      wr(1, 1'b1, x[1:0]);
      await(1, 1'b1, 5);
      chk("reverse", 0, rev[1]);
      for (n = 0; n < 400 && gate[1] === 1'b1; n++) tick(1);
      if (gate[1] === 1'b1) close_out();
      chk("on time", 1, (n + 3 >= (x == 3 ? 16 : 1 << x) * BC) &&
        (n <= (x == 3 ? 16 : 1 << x) * BC + 3));
      chk("enable", 0, en[1]);
    end
    stall[1] <= 1'b0;
    tick(20);
    chk("gate", 0, gate[1]);
    @(posedge clk);
    ctrl[1].discharge_enable <= 1'b0;
    tick(2);
    chk("discharge", 0, dis[1]);
    $display("timer test done");
  endtask : t_timer
  task t_limit;
    @(posedge clk);
    m_wr <= 2'h1;
    @(posedge clk);
    m_wr <= 2'h0;
    limit[0] <= 1'b1;
    tick(3);
    chk("irq oe", 1, irq_oe);
    chk("cause", 1, cause[0]);
    chk("mask", 2'h2, mask);
    await(0, 1'b0, 30);
    limit[0] <= 1'b0;
    tick(2);
    @(posedge clk);
    st_wr <= 1'b1;
    @(posedge clk);
    st_wr <= 1'b0;
    tick(2);
    chk("irq oe", 0, irq_oe);
    chk("cause", 0, cause);
    $display("overload test done");
  endtask : t_limit
  task t_loss;
    wr(0, 1'b1, 2'h0);
    await(0, 1'b1, 5);
    @(posedge clk);
    b2_en <= 1'b0;
    await(0, 1'b0, 10);
    chk("enable", 1, en[0]);
    @(posedge clk);
    b2_en <= 1'b1;
    await(0, 1'b1, 12);
    @(posedge clk);
    b1_en <= 1'b0;
    await(0, 1'b0, 10);
    @(posedge clk);
    b1_en <= 1'b1;
    await(0, 1'b1, 12);
    @(posedge clk);
    hot[0] <= 1'b1;
    await(0, 1'b0, 4);
    chk("discharge", 1, dis[0]);
    $display("supply and heat test done");
  endtask : t_loss
  initial begin
    {reset_n, b1_en, b1_ok, b2_en, b2_ok, st_wr, st_val} = '0;
    {m_wr, m_val, stall, limit, hot} = '0;
    ctrl[0] = '0;
    ctrl[1] = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_blocked();
    t_on();
    t_timer();
    t_limit();
    t_loss();
    close_out();
  end
endmodule : lsc_top_tb
